// ===== design/wdtrf_top.sv
// Watchdog timer with reset-cause flags, APB slave.
// Assumes one 25 MHz clock; reset input acts as power-on reset;
// chip reset events arrive as one-cycle pulses from the core.
//
// Overview of operation
// - Counter ticks at 128 kHz, not system clock
// - Counter restarts on restart, disable, chip reset
// - Ten periods; reset-mode timeout resets the chip
// - Enable and irq-enable pick stop, interrupt, reset
// - Fuse picks safety level one or two
// - Level one: enable write of one always accepted
// - Level one disable: unlock write, then second write
// - Level two: always enabled, enable reads one
// - Level two period change needs unlock sequence
// - Watchdog, brown-out, pin flags set; POR/zero clear
// - Power-on flag sets on POR, clears by zero
// - Reset-cause bits seven to four read zero
// - Control register layout and reset values
// - Timeout flag set; cleared by vector or one
// - Irq request needs global and watchdog enable
// - Timeout with enable and irq enable both set clears irq enable
// - Unlock bit clears four cycles after set
// - Clearing enable or period needs unlock set
// - Level one: reset flag forces enable on
// - Period codes map 2K to 1024K ticks
// - Reset pulse one system clock long
`timescale 1ns/1ps

module wdtrf_top #(
  parameter int TICK_DIV   = wdtrf_pkg::TICK_DIV,
  parameter int BASE_TICKS = wdtrf_pkg::BASE_TICKS
) (
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [wdtrf_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         watchdogSafetyFuse,
  input  wire logic                         restartInstruction,
  input  wire logic                         brownoutReset,
  input  wire logic                         pinReset,
  input  wire logic                         coreIrqEnable,
  input  wire logic                         vectorTaken,
  output logic                              wdIrqRequest,
  output logic                              wdResetPulse
);

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  logic [7:0]  divCount;
  logic        wdTick;
  logic [23:0] wdCount;
  logic [23:0] wdLimit;
  logic        timeoutHit;
  logic        timeoutReset;
  logic        chipReset;
  logic        levelTwo;
  logic        running;
  logic        enableEff;
  logic        enable;
  logic        irqEnable;
  logic        timeoutFlag;
  logic [3:0]  period;
  logic        unlock;
  logic [2:0]  unlockCount;
  logic        wdCause;
  logic        brownoutCause;
  logic        pinCause;
  logic        poweronCause;
  logic        apbWrite;
  logic        ctrlWrite;
  logic        causeWrite;
  logic [7:0]  wrByte;
  logic [3:0]  newPeriod;
  logic [7:0]  ctrlView;
  logic [7:0]  causeView;
  logic [23:0] next_wdCount;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        wrFlagClear;
  logic        wrIrqEnable;
  logic        wrUnlock;
  logic        wrEnable;
  logic        clearWdCause;
  logic        clearBoCause;
  logic        clearPinCause;
  logic        clearPoCause;

  // ----------------------------------------------------------
  // Safety level and mode decode
  // ----------------------------------------------------------
  // Fuse high means programmed: safety level two
  assign levelTwo = watchdogSafetyFuse;
  // Level two pins enable on; level one lets the reset flag hold it
  assign enableEff = levelTwo | enable | wdCause;
  assign running   = enableEff | irqEnable;

  // ----------------------------------------------------------
  // Watchdog tick divider
  // ----------------------------------------------------------
  // One clock only, so the oscillator is modelled as an enable
  // pulse; no crossing is then needed for tick or restart.
  always_ff @(posedge clk) begin
    if (reset) begin
      divCount <= 8'h00;
      wdTick   <= 1'b0;
    end else if (divCount == 8'(TICK_DIV - 1)) begin
      divCount <= 8'h00;
      wdTick   <= 1'b1;
    end else begin
      divCount <= divCount + 8'h01;
      wdTick   <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Timeout counter
  // ----------------------------------------------------------
  assign wdLimit = 24'(BASE_TICKS) << period;

  assign timeoutHit   = running & wdTick
                      & (wdCount == wdLimit - 24'h000001);
  // Interrupt wins when both enable bits are set
  assign timeoutReset = timeoutHit & enableEff & ~irqEnable;
  // Every chip reset clears control and restarts the count
  assign chipReset    = timeoutReset | brownoutReset | pinReset;

  // Restart and timeout both start a fresh period from zero
  always_comb begin
    next_wdCount = wdCount;
    if (chipReset || restartInstruction || !running) begin
      next_wdCount = 24'h000000;
    end else if (timeoutHit) begin
      next_wdCount = 24'h000000;
    end else if (wdTick) begin
      next_wdCount = wdCount + 24'h000001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wdCount <= 24'h000000;
    end else begin
      wdCount <= next_wdCount;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wdResetPulse <= 1'b0;
    end else begin
      wdResetPulse <= timeoutReset;
    end
  end

  // ----------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------
  // Ready is raised in the first access cycle: no wait states
  assign apbWrite   = psel & penable & pready & pwrite;
  assign ctrlWrite  = apbWrite & (paddr == wdtrf_pkg::CTRL_ADDR);
  assign causeWrite = apbWrite & (paddr == wdtrf_pkg::CAUSE_ADDR);
  assign wrByte     = pwdata[7:0];
  assign newPeriod  = {wrByte[wdtrf_pkg::CTRL_P3_BIT],
                       wrByte[wdtrf_pkg::CTRL_P0_BIT +: 3]};

  // Field strobes and data bits of a control or cause write
  assign wrFlagClear   = ctrlWrite & wrByte[wdtrf_pkg::CTRL_FLAG_BIT];
  assign wrIrqEnable   = wrByte[wdtrf_pkg::CTRL_IE_BIT];
  assign wrUnlock      = ctrlWrite & wrByte[wdtrf_pkg::CTRL_UNLOCK_BIT];
  assign wrEnable      = wrByte[wdtrf_pkg::CTRL_EN_BIT];
  assign clearWdCause  = causeWrite & ~wrByte[wdtrf_pkg::CAUSE_WD_BIT];
  assign clearBoCause  = causeWrite & ~wrByte[wdtrf_pkg::CAUSE_BO_BIT];
  assign clearPinCause = causeWrite & ~wrByte[wdtrf_pkg::CAUSE_PIN_BIT];
  assign clearPoCause  = causeWrite & ~wrByte[wdtrf_pkg::CAUSE_PO_BIT];

  assign ctrlView = {timeoutFlag, irqEnable, period[3], unlock,
                     enableEff, period[2:0]};
  assign causeView = {4'h0, wdCause, brownoutCause, pinCause,
                      poweronCause};

  // Read data is picked in the setup cycle, held through access
  always_comb begin
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    if (paddr == wdtrf_pkg::CTRL_ADDR) begin
      next_prdata = {24'h000000, ctrlView};
    end else if (paddr == wdtrf_pkg::CAUSE_ADDR) begin
      next_prdata = {24'h000000, causeView};
    end else begin
      next_pslverr = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Change-unlock window
  // ----------------------------------------------------------
  // Opens only on a write with unlock and enable both at one
  // A repeated unlock write restarts the four-cycle count
  always_ff @(posedge clk) begin
    if (reset || chipReset) begin
      unlock      <= 1'b0;
      unlockCount <= 3'h0;
    end else if (wrUnlock && wrEnable) begin
      unlock      <= 1'b1;
      unlockCount <= wdtrf_pkg::UNLOCK_CYCLES;
    end else if (unlock) begin
      if (unlockCount == 3'h1) begin
        unlock <= 1'b0;
      end
      unlockCount <= unlockCount - 3'h1;
    end
  end

  // ----------------------------------------------------------
  // Enable and period
  // ----------------------------------------------------------
  // Stored enable matters only in level one
  always_ff @(posedge clk) begin
    if (reset || chipReset) begin
      enable <= wdtrf_pkg::CTRL_RESET[wdtrf_pkg::CTRL_EN_BIT];
    end else if (ctrlWrite && !levelTwo) begin
      if (wrEnable) begin
        enable <= 1'b1;
      end else if (unlock) begin
        enable <= 1'b0;
      end
    end
  end

  // Reserved codes are dropped so the period stays legal
  always_ff @(posedge clk) begin
    if (reset || chipReset) begin
      period <= 4'h0;
    end else if (ctrlWrite && unlock
                 && newPeriod <= wdtrf_pkg::PERIOD_MAX) begin
      period <= newPeriod;
    end
  end

  // ----------------------------------------------------------
  // Interrupt enable, flag and request
  // ----------------------------------------------------------
  // A software write outranks the hardware clear
  always_ff @(posedge clk) begin
    if (reset || chipReset) begin
      irqEnable <= 1'b0;
    end else if (ctrlWrite) begin
      irqEnable <= wrIrqEnable;
    end else if (timeoutHit && enableEff && irqEnable) begin
      irqEnable <= 1'b0;
    end
  end

  // Set beats vector or write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset || chipReset) begin
      timeoutFlag <= 1'b0;
    end else if (timeoutHit && irqEnable) begin
      timeoutFlag <= 1'b1;
    end else if (vectorTaken || wrFlagClear) begin
      timeoutFlag <= 1'b0;
    end
  end

  // Registered, so the request lags the flag by one clock
  always_ff @(posedge clk) begin
    if (reset) begin
      wdIrqRequest <= 1'b0;
    end else begin
      wdIrqRequest <= timeoutFlag & irqEnable & coreIrqEnable;
    end
  end

  // ----------------------------------------------------------
  // Reset-cause flags
  // ----------------------------------------------------------
  // The block reset is the power-on reset
  always_ff @(posedge clk) begin
    if (reset) begin
      wdCause <= wdtrf_pkg::CAUSE_RESET[wdtrf_pkg::CAUSE_WD_BIT];
    end else if (timeoutReset) begin
      wdCause <= 1'b1;
    end else if (clearWdCause) begin
      wdCause <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      brownoutCause <= wdtrf_pkg::CAUSE_RESET[wdtrf_pkg::CAUSE_BO_BIT];
    end else if (brownoutReset) begin
      brownoutCause <= 1'b1;
    end else if (clearBoCause) begin
      brownoutCause <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pinCause <= wdtrf_pkg::CAUSE_RESET[wdtrf_pkg::CAUSE_PIN_BIT];
    end else if (pinReset) begin
      pinCause <= 1'b1;
    end else if (clearPinCause) begin
      pinCause <= 1'b0;
    end
  end

  // Chip resets leave it alone; only the block reset sets it
  always_ff @(posedge clk) begin
    if (reset) begin
      poweronCause <= wdtrf_pkg::CAUSE_RESET[wdtrf_pkg::CAUSE_PO_BIT];
    end else if (clearPoCause) begin
      poweronCause <= 1'b0;
    end
  end

endmodule : wdtrf_top

// ===== inc/wdtrf_pkg.sv
// Constants for the watchdog timer with reset-cause flags.
// Assumes a 25 MHz system clock and an APB register port.
package wdtrf_pkg;

  // ----------------------------------------------------------
  // Clocking and timing
  // ----------------------------------------------------------
  localparam int CLK_HZ    = 25_000_000;
  localparam int WD_OSC_HZ = 128_000;
  // Nearest whole divide; the tick runs about 0.2 % fast
  localparam int TICK_DIV  = CLK_HZ / WD_OSC_HZ;
  // Timeout of period code zero, in watchdog ticks
  localparam int BASE_TICKS = 2048;
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam logic [3:0] PERIOD_MAX    = 4'h9;

  // ----------------------------------------------------------
  // Register map (index, byte address is four times it)
  // ----------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [7:0] CTRL_INDEX  = 8'h21;
  localparam logic [7:0] CAUSE_INDEX = 8'h22;
  localparam logic [ADDR_W-1:0] CTRL_ADDR  = {2'h0, CTRL_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] CAUSE_ADDR = {2'h0, CAUSE_INDEX, 2'h0};

  // ----------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------
  localparam int CTRL_FLAG_BIT   = 7;
  localparam int CTRL_IE_BIT     = 6;
  localparam int CTRL_P3_BIT     = 5;
  localparam int CTRL_UNLOCK_BIT = 4;
  localparam int CTRL_EN_BIT     = 3;
  localparam int CTRL_P0_BIT     = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------
  // Reset-cause register fields
  // ----------------------------------------------------------
  localparam int CAUSE_WD_BIT  = 3;
  localparam int CAUSE_BO_BIT  = 2;
  localparam int CAUSE_PIN_BIT = 1;
  localparam int CAUSE_PO_BIT  = 0;
  localparam logic [7:0] CAUSE_RESET = 8'h01;

endpackage : wdtrf_pkg

// ===== testbench/wdtrf_chk.sv
// Checker for the watchdog block: APB answers and event outputs.
// Assumes one clock domain; bound into every wdtrf_top.
`timescale 1ns/1ps

module wdtrf_chk #(
  parameter int TICK_DIV   = 2,
  parameter int BASE_TICKS = 4
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        watchdogSafetyFuse,
  input wire logic        restartInstruction,
  input wire logic        brownoutReset,
  input wire logic        pinReset,
  input wire logic        coreIrqEnable,
  input wire logic        vectorTaken,
  input wire logic        wdIrqRequest,
  input wire logic        wdResetPulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rd(a);
    pready && !pwrite && paddr == a;
  endsequence
  chk_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_unmapped: assert property (s_setup ##0
    (paddr != wdtrf_pkg::CTRL_ADDR && paddr != wdtrf_pkg::CAUSE_ADDR)
    |=> pready && pslverr) else $error("unmapped not refused");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_cause_rsvd: assert property (s_rd(wdtrf_pkg::CAUSE_ADDR)
    |-> prdata[7:4] == 4'h0) else $error("reserved bits set");
  chk_lvl2_enable: assert property (s_rd(wdtrf_pkg::CTRL_ADDR)
    ##0 watchdogSafetyFuse |-> prdata[3]) else $error("enable low");
  chk_pulse_single: assert property (wdResetPulse |=> !wdResetPulse)
    else $error("reset pulse too long");
  chk_irq_gate: assert property (wdIrqRequest |-> $past(coreIrqEnable))
    else $error("irq without global enable");
  chk_vector_clear: assert property (vectorTaken |=> ##1 !wdIrqRequest)
    else $error("irq kept after vector");
endmodule : wdtrf_chk

bind wdtrf_top wdtrf_chk #(.TICK_DIV(TICK_DIV), .BASE_TICKS(BASE_TICKS))
  chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .watchdogSafetyFuse(watchdogSafetyFuse),
  .restartInstruction(restartInstruction), .brownoutReset(brownoutReset),
  .pinReset(pinReset), .coreIrqEnable(coreIrqEnable),
  .vectorTaken(vectorTaken), .wdIrqRequest(wdIrqRequest),
  .wdResetPulse(wdResetPulse));

// ===== testbench/test_watchdog_timer_with_reset_flags.sv
// Self-checking bench for the watchdog block, driven over APB.
// Assumes TICK_DIV 2 and BASE_TICKS 64: period 0 is 128 clocks.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR %0t: got %h want %h", $time, a, e); end end

module test_watchdog_timer_with_reset_flags;
  localparam logic [11:0] CT = wdtrf_pkg::CTRL_ADDR;
  localparam logic [11:0] CA = wdtrf_pkg::CAUSE_ADDR;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, wdIrqRequest, wdResetPulse, rerr;
  logic fuse = 0, rst = 0, bo = 0, pin = 0, gie = 0, vec = 0;
  logic [7:0] rdat;
  int n_errors = 0, tests_run = 0, nPulse = 0, c, p;

  wdtrf_top #(.TICK_DIV(2), .BASE_TICKS(64)) uut (.clk(clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watchdogSafetyFuse(fuse),
    .restartInstruction(rst), .brownoutReset(bo), .pinReset(pin),
    .coreIrqEnable(gie), .vectorTaken(vec), .wdIrqRequest(wdIrqRequest),
    .wdResetPulse(wdResetPulse));

  always #20 clk = ~clk;
  always @(posedge clk) if (wdResetPulse === 1'h1) nPulse <= nPulse + 1;

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 1'h0; penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'h0, a, 8'h00);
    `CHK(rdat, e)
  endtask : rd
  task automatic pulse(input int k);
    rst <= (k == 0); bo <= (k == 1); pin <= (k == 2); vec <= (k == 3);
    @(posedge clk);
    rst <= 1'h0; bo <= 1'h0; pin <= 1'h0; vec <= 1'h0;
  endtask : pulse
  task automatic waitRst();
    c = 0;
    while (wdResetPulse !== 1'h1) begin
      @(posedge clk);
      c++;
    end
    @(posedge clk);
  endtask : waitRst
  task automatic pollFlag();
    rdat = 8'h00;
    while (rdat[7] !== 1'h1) apb(1'h0, CT, 8'h00);
  endtask : pollFlag
  task automatic doReset();
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
  endtask : doReset
  task automatic print_verdict();
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  initial begin
    doReset();
    rd(CT, 8'h00);
    rd(CA, 8'h01);
    apb(1'h0, 12'h0FC, 8'h00);
    `CHK(rerr, 1'h1)
    wr(CA, 8'h00);
    rd(CA, 8'h00);
    pulse(2);
    rd(CA, 8'h02);
    pulse(1);
    wr(CA, 8'hFF);
    rd(CA, 8'h06);
    wr(CA, 8'h00);
    gie <= 1'h1;
    wr(CT, 8'h40);
    pollFlag();
    `CHK(rdat, 8'hC0)
    repeat (2) @(posedge clk);
    `CHK(wdIrqRequest, 1'h1)
    pulse(3);
    rd(CT, 8'h40);
    wr(CT, 8'h80);
    rd(CT, 8'h00);
    wr(CT, 8'h48);
    pollFlag();
    `CHK(rdat, 8'h88)
    waitRst();
    rd(CA, 8'h08);
    wr(CT, 8'h00);
    rd(CT, 8'h08);
    wr(CA, 8'h00);
    wr(CT, 8'h08);
    wr(CT, 8'h00);
    rd(CT, 8'h08);
    wr(CT, 8'h18);
    rd(CT, 8'h18);
    repeat (6) @(posedge clk);
    rd(CT, 8'h08);
    wr(CT, 8'h00);
    rd(CT, 8'h08);
    wr(CT, 8'h18);
    wr(CT, 8'h00);
    rd(CT, 8'h00);
    p = nPulse;
    repeat (300) @(posedge clk);
    `CHK(nPulse, p)
    wr(CT, 8'h08);
    pulse(0);
    waitRst();
    `CHK(c inside {[120:140]}, 1'h1)
    wr(CA, 8'h00);
    wr(CT, 8'h18);
    wr(CT, 8'h09);
    pulse(0);
    waitRst();
    `CHK(c inside {[248:270]}, 1'h1)
    wr(CA, 8'h00);
    wr(CT, 8'h18);
    wr(CT, 8'h2A);
    rd(CT, 8'h08);
    p = nPulse;
    repeat (8) begin
      repeat (60) @(posedge clk);
      pulse(0);
    end
    `CHK(nPulse, p)
    wr(CT, 8'h18);
    wr(CT, 8'h00);
    fuse <= 1'h1;
    doReset();
    rd(CT, 8'h08);
    wr(CT, 8'h18);
    wr(CT, 8'h00);
    rd(CT, 8'h08);
    wr(CT, 8'h18);
    wr(CT, 8'h01);
    rd(CT, 8'h09);
    print_verdict();
  end
endmodule : test_watchdog_timer_with_reset_flags
